/* include/dfc_pkg.sv */
// constants, types and register map of the dma flow-control and tcb check block
package dfc_pkg;
  localparam int NCH = 14;
  localparam logic [7:0] OFS_FLOW = 8'h00;
  localparam logic [7:0] OFS_SET = 8'h04;
  localparam logic [7:0] OFS_CLR = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_IDX = 8'h10;
  localparam logic [7:0] OFS_XW = 8'h14;
  localparam logic [7:0] OFS_YW = 8'h18;
  localparam logic [7:0] OFS_COMMIT = 8'h1C;
  localparam logic [7:0] OFS_ERR = 8'h20;
  localparam logic [7:0] OFS_ACT = 8'h24;
  localparam logic [7:0] OFS_SYS = 8'h28;
  localparam logic [31:0] FLOW_RST = 32'h0000_0000;
  // staging control word fields
  localparam int CW_KIND_LSB = 0;
  localparam int CW_SIZE_LSB = 3;
  localparam int CW_GATE_BIT = 5;
  localparam int CW_2D_BIT = 6;
  localparam int CW_CH_LSB = 8;
  localparam int CW_SIDE_BIT = 12;
  // address windows, plain defaults
  localparam logic [31:0] LINK_TX_BASE = 32'h0018_0000;
  localparam logic [31:0] LINK_TX_MASK = 32'hFFFF_FFF0;
  localparam logic [31:0] INT_REG_BASE = 32'h0018_0000;
  localparam logic [3:0] FIRST_LINK_TX = 4'h4;
  localparam logic [3:0] FIRST_LINK_RX = 4'h8;
  localparam logic [3:0] FIRST_SLAVE_WR = 4'hC;

  typedef enum logic [2:0] {
    K_OFF = 3'b000, K_LINK = 3'b001, K_INT = 3'b010, K_RSV3 = 3'b011,
    K_EXT = 3'b100, K_FLY = 3'b101, K_BOOT = 3'b110, K_RSV7 = 3'b111
  } dfc_kind_e;

  typedef enum logic [1:0] {
    SZ_RSV = 2'b00, SZ_NORM = 2'b01, SZ_LONG = 2'b10, SZ_QUAD = 2'b11
  } dfc_size_e;

  typedef struct packed {
    dfc_kind_e kind;
    dfc_size_e size;
    logic gate;
    logic two_d;
    logic [31:0] index;
    logic [15:0] x_count;
    logic [15:0] x_stride;
    logic [15:0] y_count;
    logic [15:0] y_stride;
  } dfc_tcb_s;

  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
  } dfc_ahb_req_s;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } dfc_ahb_rsp_s;
endpackage : dfc_pkg

/* src/dfc_core.sv */
// dma flow-control register, tcb configuration checks and channel request logic
// Notes on behaviour
// - a set flow bit stops new requests of its channel; clearing resumes them
// - flow register is all zeros after reset
// - set alias ORs the written word into the flow register
// - clear alias ANDs the written word into the flow register
// - active link channel requests at once when its buffer allows
// - one rx and tx channel per link; fixed priority, any rx over any tx, link 3 highest within each
// - an external-port channel with its gate bit set handshakes on its own request pin; ungated it requests at once
// - master write to slave register 0 or 1 requests channel 12 or 13
// - write to uninitialised slave-write channel is dropped and flagged
// - kind codes: 0 off, 1 link, 2 int, 4 ext, 5 flyby, 6 boot
// - size codes: 1 normal, 2 long, 3 quad, 0 reserved
// - illegal configuration sets the channel's error status
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module dfc_core (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire dfc_pkg::dfc_ahb_req_s AHB_REQ_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HWDATA_I,
  output dfc_pkg::dfc_ahb_rsp_s AHB_RSP_O,
  input wire logic [3:0] LINK_TXE_I,
  input wire logic [3:0] LINK_RXNE_I,
  input wire logic [3:0] EP_REQUEST_PIN_I,
  input wire logic [1:0] SLAVE_WR_I,
  output logic [7:0] LINK_REQ_O,
  output logic [3:0] LINK_SEL_O,
  output logic [3:0] EP_REQ_O,
  output logic [1:0] SW_REQ_O,
  output logic [31:0] FLOW_SUSPEND_O,
  output logic [13:0] CH_ACTIVE_O
);
  import dfc_pkg::*;

  logic [31:0] flow_r;
  dfc_tcb_s stage_r;
  logic [3:0] tch_r;
  logic tside_r;
  logic wr_pend_r;
  logic [7:0] waddr_r;
  logic [NCH-1:0] err_r;
  logic [NCH-1:0] act_w;
  logic [1:0] sys_r;
  dfc_kind_e kind_r [NCH][2];
  dfc_size_e ep_size_r [4][2];
  logic ep_gate_r [4][2];
  logic [31:0] ep_tot_r [4][2];
  logic [13:0] sync1_r;
  logic [13:0] sync2_r;
  logic [1:0] sw_d_r;
  logic [1:0] sw_pend_r;
  logic [31:0] rd_mux;
  logic [31:0] ctrl_rd;
  logic chk_err;
  logic [31:0] tot;
  logic addr_ok;
  logic do_commit;
  logic ep;
  logic [1:0] ech;
  logic [1:0] sw_pulse;
  logic [1:0] sw_issue;
  logic [7:0] link_req_nxt;
  logic [3:0] link_sel_nxt;
  logic [3:0] ep_req_nxt;
  logic [NCH-1:0] err_clr;

  function automatic logic pair_ok(input dfc_kind_e src, input dfc_kind_e dst);
    logic ok;
    ok = 1'b0;
    case (src)
      K_OFF: ok = 1'b1;
      K_INT: ok = (dst == K_EXT) || (dst == K_BOOT);
      K_EXT: ok = (dst == K_INT) || (dst == K_FLY);
      K_FLY: ok = (dst == K_EXT);
      K_BOOT: ok = (dst == K_INT);
      default: ok = 1'b0;
    endcase
    return ok || (dst == K_OFF);
  endfunction : pair_ok

  // ahb-lite slave, zero wait states
  assign addr_ok = AHB_REQ_I.hsel & AHB_REQ_I.htrans[1] & HREADY_I;
  assign do_commit = wr_pend_r && (waddr_r == OFS_COMMIT) && (tch_r < 4'(NCH));
  assign ep = (tch_r < FIRST_LINK_TX);
  assign ech = tch_r[1:0];

  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[CW_KIND_LSB +: 3] = stage_r.kind;
    ctrl_rd[CW_SIZE_LSB +: 2] = stage_r.size;
    ctrl_rd[CW_GATE_BIT] = stage_r.gate;
    ctrl_rd[CW_2D_BIT] = stage_r.two_d;
    ctrl_rd[CW_CH_LSB +: 4] = tch_r;
    ctrl_rd[CW_SIDE_BIT] = tside_r;
    case (AHB_REQ_I.haddr[7:0])
      OFS_FLOW: rd_mux = flow_r;
      OFS_CTRL: rd_mux = ctrl_rd;
      OFS_IDX: rd_mux = stage_r.index;
      OFS_XW: rd_mux = {stage_r.x_stride, stage_r.x_count};
      OFS_YW: rd_mux = {stage_r.y_stride, stage_r.y_count};
      OFS_ERR: rd_mux = {18'h0_0000, err_r};
      OFS_ACT: rd_mux = {18'h0_0000, act_w};
      OFS_SYS: rd_mux = {30'h0000_0000, sys_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
      AHB_RSP_O <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000};
    end else begin
      wr_pend_r <= addr_ok & AHB_REQ_I.hwrite;
      waddr_r <= AHB_REQ_I.haddr[7:0];
      AHB_RSP_O.hreadyout <= 1'b1;
      AHB_RSP_O.hresp <= 1'b0;
      if (addr_ok && !AHB_REQ_I.hwrite) begin
        AHB_RSP_O.hrdata <= rd_mux;
      end
    end
  end

  // flow-control register and its aliases
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      flow_r <= FLOW_RST;
    end else if (wr_pend_r) begin
      case (waddr_r)
        OFS_FLOW: flow_r <= HWDATA_I;
        OFS_SET: flow_r <= flow_r | HWDATA_I;
        OFS_CLR: flow_r <= flow_r & HWDATA_I;
        default: flow_r <= flow_r;
      endcase
    end
  end
  assign FLOW_SUSPEND_O = flow_r;

  // tcb staging registers
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      stage_r <= '0;
      tch_r <= 4'h0;
      tside_r <= 1'b0;
    end else if (wr_pend_r) begin
      case (waddr_r)
        OFS_CTRL: begin
          stage_r.kind <= dfc_kind_e'(HWDATA_I[CW_KIND_LSB +: 3]);
          stage_r.size <= dfc_size_e'(HWDATA_I[CW_SIZE_LSB +: 2]);
          stage_r.gate <= HWDATA_I[CW_GATE_BIT];
          stage_r.two_d <= HWDATA_I[CW_2D_BIT];
          tch_r <= HWDATA_I[CW_CH_LSB +: 4];
          tside_r <= HWDATA_I[CW_SIDE_BIT];
        end
        OFS_IDX: stage_r.index <= HWDATA_I;
        OFS_XW: {stage_r.x_stride, stage_r.x_count} <= HWDATA_I;
        OFS_YW: {stage_r.y_stride, stage_r.y_count} <= HWDATA_I;
        default: stage_r <= stage_r;
      endcase
    end
  end

  // configuration check of the staged block
  always_comb begin
    chk_err = 1'b0;
    tot = stage_r.two_d ? 32'(stage_r.x_count) * 32'(stage_r.y_count) : {16'h0000, stage_r.x_count};
    if (stage_r.kind == K_RSV3 || stage_r.kind == K_RSV7 || stage_r.size == SZ_RSV) chk_err = 1'b1;
    if (stage_r.kind != K_OFF) begin
      if (stage_r.x_count == 16'h0000) chk_err = 1'b1;
      if (stage_r.two_d && stage_r.y_count <= 16'h0001) chk_err = 1'b1;
      if (stage_r.size == SZ_LONG && (stage_r.index[0] | stage_r.x_stride[0] | stage_r.x_count[0]
          | (stage_r.two_d & stage_r.y_stride[0]))) chk_err = 1'b1;
      if ((stage_r.size == SZ_QUAD || stage_r.kind == K_BOOT) && ((|stage_r.index[1:0])
          | (|stage_r.x_stride[1:0]) | (|stage_r.x_count[1:0])
          | (stage_r.two_d & (|stage_r.y_stride[1:0])))) chk_err = 1'b1;
      case (stage_r.kind)
        K_LINK: if ((stage_r.index & LINK_TX_MASK) != LINK_TX_BASE) chk_err = 1'b1;
        K_INT: if (stage_r.index >= INT_REG_BASE) chk_err = 1'b1;
        K_EXT: if (stage_r.index[31:22] == 10'h000) chk_err = 1'b1;
        default: chk_err = chk_err;
      endcase
      if (tch_r >= FIRST_LINK_TX && tch_r < FIRST_SLAVE_WR && stage_r.size != SZ_QUAD) chk_err = 1'b1;
      if (tch_r >= FIRST_LINK_TX && tch_r < FIRST_LINK_RX && stage_r.kind != K_INT && stage_r.kind != K_EXT)
        chk_err = 1'b1;
      if (tch_r >= FIRST_LINK_RX && tch_r < FIRST_SLAVE_WR && stage_r.kind != K_LINK
          && stage_r.kind != K_INT && stage_r.kind != K_EXT) chk_err = 1'b1;
      if (tch_r >= FIRST_SLAVE_WR && (stage_r.kind != K_INT || !stage_r.gate)) chk_err = 1'b1;
      if (ep && stage_r.kind == K_BOOT && stage_r.size != SZ_NORM) chk_err = 1'b1;
      if (ep && kind_r[ech][~tside_r] != K_OFF) begin
        if (ep_size_r[ech][~tside_r] != stage_r.size || ep_gate_r[ech][~tside_r] != stage_r.gate
            || ep_tot_r[ech][~tside_r] != tot) chk_err = 1'b1;
        if (tside_r ? !pair_ok(kind_r[ech][0], stage_r.kind) : !pair_ok(stage_r.kind, kind_r[ech][1]))
          chk_err = 1'b1;
      end
    end
  end

  // committed channel state
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int c = 0; c < NCH; c++) begin
        kind_r[c][0] <= K_OFF;
        kind_r[c][1] <= K_OFF;
      end
      for (int c = 0; c < 4; c++) begin
        for (int s = 0; s < 2; s++) begin
          ep_size_r[c][s] <= SZ_RSV;
          ep_gate_r[c][s] <= 1'b0;
          ep_tot_r[c][s] <= 32'h0000_0000;
        end
      end
    end else if (do_commit) begin
      kind_r[tch_r][ep & tside_r] <= chk_err ? K_OFF : stage_r.kind;
      if (ep && !chk_err) begin
        ep_size_r[ech][tside_r] <= stage_r.size;
        ep_gate_r[ech][tside_r] <= stage_r.gate & (stage_r.kind != K_OFF);
        ep_tot_r[ech][tside_r] <= tot;
      end
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_act
    assign act_w[c] = (kind_r[c][0] != K_OFF) || (kind_r[c][1] != K_OFF);
    assign err_clr[c] = (wr_pend_r && waddr_r == OFS_ERR && HWDATA_I[c])
                        || (do_commit && !chk_err && tch_r == 4'(c));
  end

  // sticky error status, set wins over clear
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      err_r <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        err_r[c] <= (err_r[c] & ~err_clr[c]) | (do_commit && chk_err && tch_r == 4'(c));
      end
    end
  end

  // pin synchronisers
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sync1_r <= 14'h0000;
      sync2_r <= 14'h0000;
      sw_d_r <= 2'b00;
    end else begin
      sync1_r <= {SLAVE_WR_I, EP_REQUEST_PIN_I, LINK_RXNE_I, LINK_TXE_I};
      sync2_r <= sync1_r;
      sw_d_r <= sync2_r[13:12];
    end
  end
  assign sw_pulse = sync2_r[13:12] & ~sw_d_r;
  assign sw_issue = sw_pend_r & ~flow_r[13:12];

  // request generation
  always_comb begin
    link_sel_nxt = 4'h0;
    for (int l = 0; l < 4; l++) begin
      link_req_nxt[l] = act_w[4 + l] & sync2_r[l] & ~flow_r[4 + l];
      link_req_nxt[4 + l] = act_w[8 + l] & sync2_r[4 + l] & ~flow_r[8 + l];
      ep_req_nxt[l] = act_w[l] & ~flow_r[l] & (~(ep_gate_r[l][0] | ep_gate_r[l][1]) | sync2_r[8 + l]);
    end
    // receive over transmit, higher link first
    for (int l = 0; l < 4; l++) begin
      if (link_req_nxt[l]) link_sel_nxt = {2'b10, 2'(l)};
    end
    for (int l = 0; l < 4; l++) begin
      if (link_req_nxt[4 + l]) link_sel_nxt = {2'b11, 2'(l)};
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      LINK_REQ_O <= 8'h00;
      LINK_SEL_O <= 4'h0;
      EP_REQ_O <= 4'h0;
      CH_ACTIVE_O <= 14'h0000;
    end else begin
      LINK_REQ_O <= link_req_nxt;
      LINK_SEL_O <= link_sel_nxt;
      EP_REQ_O <= ep_req_nxt;
      CH_ACTIVE_O <= act_w;
    end
  end

  // slave-write requests and discard flags
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sw_pend_r <= 2'b00;
      SW_REQ_O <= 2'b00;
      sys_r <= 2'b00;
    end else begin
      sw_pend_r <= (sw_pend_r & ~sw_issue) | (sw_pulse & act_w[13:12]);
      SW_REQ_O <= sw_issue;
      // discard flag, set wins over clear
      sys_r <= (sys_r & ~((wr_pend_r && waddr_r == OFS_SYS) ? HWDATA_I[1:0] : 2'b00))
               | (sw_pulse & ~act_w[13:12]);
    end
  end

  // checks
  logic seen_r;
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) seen_r <= 1'b0;
    else seen_r <= 1'b1;
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  a_flow_reset_zero:
    assert property (!seen_r |-> flow_r == 32'h0000_0000) else $error("flow not zero after reset");
  a_set_alias_or:
    assert property (wr_pend_r && waddr_r == OFS_SET |=> flow_r == ($past(flow_r) | $past(HWDATA_I)))
    else $error("set alias wrong");
  a_clr_alias_and:
    assert property (wr_pend_r && waddr_r == OFS_CLR |=> flow_r == ($past(flow_r) & $past(HWDATA_I)))
    else $error("clear alias wrong");
  a_link_suspend_gate:
    assert property (1'b1 |=> (LINK_REQ_O & $past(flow_r[11:4])) == 8'h00) else $error("suspended link requests");
  a_ep_suspend_gate:
    assert property (1'b1 |=> (EP_REQ_O & $past(flow_r[3:0])) == 4'h0) else $error("suspended ep requests");
  a_link_tx_raise:
    assert property (act_w[4] && sync2_r[0] && !flow_r[4] |=> LINK_REQ_O[0]) else $error("link request missing");
  a_bad_cfg_flag:
    assert property (do_commit && chk_err |=> err_r[$past(tch_r)]
                     && kind_r[$past(tch_r)][$past(ep & tside_r)] == K_OFF)
    else $error("illegal block not flagged");
  a_sw_discard_flag:
    assert property (sw_pulse[1] && !act_w[13] |=> sys_r[1] && !sw_pend_r[1]) else $error("discard not flagged");
  a_sw_req_issue:
    assert property (sw_pulse[0] && act_w[12] && !flow_r[12] ##1 !flow_r[12] |=> SW_REQ_O[0])
    else $error("slave write request missing");
  a_link_quad_only:
    assert property (do_commit && tch_r == 4'h5 && stage_r.kind != K_OFF && stage_r.size != SZ_QUAD |=> err_r[5])
    else $error("link size not checked");

  c_set_alias: cover property (wr_pend_r && waddr_r == OFS_SET);
  c_bad_commit: cover property (do_commit && chk_err);
  c_sw_request: cover property (SW_REQ_O[0]);
  c_ep_gated: cover property (EP_REQ_O[0] && ep_gate_r[0][0]);
endmodule : dfc_core

/* dv/dfc_far.sv */
// far-side model: link buffers, request pins, external master writes
`timescale 1ns/10ps
module dfc_far (
  input wire logic clk_i,
  output logic [3:0] txe_o,
  output logic [3:0] rxne_o,
  output logic [3:0] pin_o,
  output logic [1:0] wr_o
);
  initial begin
    txe_o = 4'h0;
    rxne_o = 4'h0;
    pin_o = 4'h0;
    wr_o = 2'h0;
  end
  task set_buf(input logic [3:0] tx, input logic [3:0] rx);
    @(posedge clk_i);
    txe_o <= tx;
    rxne_o <= rx;
  endtask : set_buf
  task set_pin(input logic [3:0] p);
    @(posedge clk_i);
    pin_o <= p;
  endtask : set_pin
  // master write strobe, prompt or slow
  task mwrite(input int i, input int hold);
    @(posedge clk_i);
    wr_o[i] <= 1'b1;
    repeat (hold) @(posedge clk_i);
    wr_o[i] <= 1'b0;
  endtask : mwrite
endmodule : dfc_far

/* dv/dfc_tb.sv */
// self-checking bench for the flow-control and tcb check block
`timescale 1ns/10ps
module tb;
  import dfc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  dfc_ahb_req_s req = '0;
  logic [31:0] hwdata = 32'h0;
  dfc_ahb_rsp_s rsp;
  logic [3:0] txe, rxne, pin, link_sel, ep_req;
  logic [1:0] swr, sw_req;
  logic [7:0] link_req;
  logic [31:0] flow, q;
  logic [13:0] act;
  int n_fail = 0;
  int checked = 0;
  always #20 clk = ~clk;
  dfc_core DUT (.CLK_I(clk), .NRST_I(nrst), .AHB_REQ_I(req), .HREADY_I(rsp.hreadyout), .HWDATA_I(hwdata),
    .AHB_RSP_O(rsp), .LINK_TXE_I(txe), .LINK_RXNE_I(rxne), .EP_REQUEST_PIN_I(pin), .SLAVE_WR_I(swr),
    .LINK_REQ_O(link_req), .LINK_SEL_O(link_sel), .EP_REQ_O(ep_req), .SW_REQ_O(sw_req),
    .FLOW_SUSPEND_O(flow), .CH_ACTIVE_O(act));
  dfc_far far (.clk_i(clk), .txe_o(txe), .rxne_o(rxne), .pin_o(pin), .wr_o(swr));
  task stop_test;
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.hreadyout !== 1'b1 && n < 20);
    if (rsp.hreadyout !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask : wait_rdy
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 2'b10, {24'h0, a}, w, 3'b010};
    wait_rdy();
    req <= '0;
    hwdata <= d;
    wait_rdy();
    q = rsp.hrdata;
  endtask : ahb
  task rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  function automatic logic [31:0] cw(input logic [3:0] ch, input dfc_kind_e k, input dfc_size_e s,
                                     input logic g, input logic td, input logic sd);
    return {19'h0, sd, ch, 1'b0, td, g, s, k};
  endfunction : cw
  task cfg(input logic [31:0] c, input logic [31:0] idx, input logic [31:0] xw, input logic [31:0] yw);
    ahb(1'b1, OFS_CTRL, c);
    ahb(1'b1, OFS_IDX, idx);
    ahb(1'b1, OFS_XW, xw);
    ahb(1'b1, OFS_YW, yw);
    ahb(1'b1, OFS_COMMIT, 32'h0);
  endtask : cfg
  task bad(input logic [31:0] c, input logic [31:0] idx, input logic [31:0] xw, input logic [31:0] yw);
    cfg(c, idx, xw, yw);
    rd(OFS_ERR, 32'h1 << c[11:8]);
    ahb(1'b0, OFS_ACT, 32'h0);
    if (c[11:8] > 4'h3) chk({31'h0, q[c[11:8]]}, 32'h0);
    ahb(1'b1, OFS_ERR, 32'h1 << c[11:8]);
  endtask : bad
  task t_reset;
    rd(OFS_FLOW, FLOW_RST);
    chk(flow, 32'h0);
    chk({31'h0, rsp.hresp}, 32'h0);
    rd(OFS_ERR, 32'h0);
  endtask : t_reset
  task t_flow;
    ahb(1'b1, OFS_FLOW, 32'hA5A5_0F0F);
    ahb(1'b1, OFS_SET, 32'h0000_F0F0);
    rd(OFS_FLOW, 32'hA5A5_FFFF);
    ahb(1'b1, OFS_CLR, 32'hFFFF_00FF);
    rd(OFS_FLOW, 32'hA5A5_00FF);
    chk(flow, 32'hA5A5_00FF);
    rd(OFS_SET, 32'h0);
    ahb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0);
    ahb(1'b1, OFS_CLR, 32'h0);
    rd(OFS_FLOW, 32'h0);
  endtask : t_flow
  task t_bad;
    bad(cw(4'h4, K_LINK, SZ_QUAD, 1'b0, 1'b0, 1'b0), 32'h1000, 32'h0004_0004, 32'h0);
    bad(cw(4'h5, K_INT, SZ_NORM, 1'b0, 1'b0, 1'b0), 32'h1000, 32'h0004_0004, 32'h0);
    bad(cw(4'h8, K_FLY, SZ_QUAD, 1'b0, 1'b0, 1'b0), 32'h0040_0000, 32'h0004_0004, 32'h0);
    bad(cw(4'h6, K_INT, SZ_QUAD, 1'b0, 1'b0, 1'b0), 32'h1000, 32'h0004_0000, 32'h0);
    bad(cw(4'h7, K_INT, SZ_QUAD, 1'b0, 1'b1, 1'b0), 32'h1000, 32'h0004_0004, 32'h0004_0001);
    bad(cw(4'h9, K_RSV3, SZ_QUAD, 1'b0, 1'b0, 1'b0), 32'h1000, 32'h0004_0004, 32'h0);
    bad(cw(4'hC, K_EXT, SZ_NORM, 1'b1, 1'b0, 1'b0), 32'h0040_0000, 32'h0001_0001, 32'h0);
    bad(cw(4'hD, K_INT, SZ_NORM, 1'b0, 1'b0, 1'b0), 32'h2000, 32'h0001_0001, 32'h0);
    bad(cw(4'hC, K_INT, SZ_LONG, 1'b1, 1'b0, 1'b0), 32'h2001, 32'h0002_0002, 32'h0);
    bad(cw(4'hD, K_INT, SZ_RSV, 1'b1, 1'b0, 1'b0), 32'h2000, 32'h0001_0001, 32'h0);
    bad(cw(4'hA, K_INT, SZ_QUAD, 1'b0, 1'b0, 1'b0), 32'h1002, 32'h0004_0004, 32'h0);
    bad(cw(4'hB, K_INT, SZ_QUAD, 1'b0, 1'b0, 1'b0), 32'h0040_0000, 32'h0004_0004, 32'h0);
  endtask : t_bad
  task t_link;
    cfg(cw(4'h4, K_INT, SZ_QUAD, 1'b0, 1'b0, 1'b0), 32'h1000, 32'h0004_0004, 32'h0);
    cfg(cw(4'hB, K_LINK, SZ_QUAD, 1'b0, 1'b0, 1'b0), LINK_TX_BASE, 32'h0004_0004, 32'h0);
    far.set_buf(4'h1, 4'h8);
    settle(5);
    chk({18'h0, act}, 32'h0000_0810);
    chk({24'h0, link_req}, 32'h81);
    chk({28'h0, link_sel}, 32'hF);
    ahb(1'b1, OFS_SET, 32'h0000_0800);
    settle(5);
    chk({24'h0, link_req}, 32'h01);
    chk({28'h0, link_sel}, 32'h8);
    ahb(1'b1, OFS_CLR, 32'hFFFF_F7FF);
    settle(5);
    chk({24'h0, link_req}, 32'h81);
    far.set_buf(4'h0, 4'h0);
  endtask : t_link
  task poll_sw(input logic [1:0] m, input logic e);
    logic hit;
    hit = 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1;
      if ((sw_req & m) == m) hit = 1'b1;
    end
    chk({31'h0, hit}, {31'h0, e});
  endtask : poll_sw
  task t_slave;
    far.mwrite(1, 4);
    settle(6);
    rd(OFS_SYS, 32'h2);
    ahb(1'b1, OFS_SYS, 32'h2);
    rd(OFS_SYS, 32'h0);
    cfg(cw(4'hC, K_INT, SZ_NORM, 1'b1, 1'b0, 1'b0), 32'h2000, 32'h0001_0001, 32'h0);
    far.mwrite(0, 1);
    poll_sw(2'b01, 1'b1);
    ahb(1'b1, OFS_SET, 32'h0000_1000);
    far.mwrite(0, 1);
    poll_sw(2'b01, 1'b0);
    ahb(1'b1, OFS_CLR, 32'hFFFF_EFFF);
    poll_sw(2'b01, 1'b1);
  endtask : t_slave
  task t_ep;
    cfg(cw(4'h0, K_INT, SZ_NORM, 1'b1, 1'b0, 1'b0), 32'h1000, 32'h0001_0008, 32'h0);
    cfg(cw(4'h0, K_EXT, SZ_NORM, 1'b1, 1'b0, 1'b1), 32'h0040_0000, 32'h0001_0008, 32'h0);
    rd(OFS_ERR, 32'h0);
    settle(5);
    chk({28'h0, ep_req}, 32'h0);
    far.set_pin(4'h1);
    settle(5);
    chk({28'h0, ep_req}, 32'h1);
    ahb(1'b1, OFS_SET, 32'h0000_0001);
    settle(5);
    chk({28'h0, ep_req}, 32'h0);
    ahb(1'b1, OFS_CLR, 32'hFFFF_FFFE);
    settle(5);
    chk({28'h0, ep_req}, 32'h1);
    far.set_pin(4'h0);
    cfg(cw(4'h1, K_FLY, SZ_NORM, 1'b1, 1'b0, 1'b0), 32'h0040_0000, 32'h0001_0008, 32'h0);
    bad(cw(4'h1, K_INT, SZ_NORM, 1'b1, 1'b0, 1'b1), 32'h1000, 32'h0001_0008, 32'h0);
    cfg(cw(4'h2, K_INT, SZ_NORM, 1'b1, 1'b0, 1'b0), 32'h1000, 32'h0001_0008, 32'h0);
    bad(cw(4'h2, K_EXT, SZ_LONG, 1'b1, 1'b0, 1'b1), 32'h0040_0000, 32'h0002_0008, 32'h0);
    bad(cw(4'h2, K_BOOT, SZ_NORM, 1'b1, 1'b0, 1'b1), 32'h0040_0002, 32'h0004_0008, 32'h0);
    cfg(cw(4'h3, K_INT, SZ_NORM, 1'b1, 1'b0, 1'b0), 32'h1000, 32'h0001_0008, 32'h0);
    bad(cw(4'h3, K_EXT, SZ_NORM, 1'b1, 1'b0, 1'b1), 32'h0040_0000, 32'h0001_0004, 32'h0);
    cfg(cw(4'h3, K_EXT, SZ_NORM, 1'b1, 1'b1, 1'b1), 32'h0040_0000, 32'h0001_0004, 32'h0001_0002);
    rd(OFS_ERR, 32'h0);
  endtask : t_ep
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_flow();
    t_bad();
    t_link();
    t_slave();
    t_ep();
    stop_test();
  end
endmodule : tb
